//--- hw/tecp_timer.sv
// 16-bit event counter, comparator counter and single pwm timer with apb registers
//
// Contract
// - counter mode counts input pin edges
// - polarity bit picks rising or falling edge
// - counting modes bypass the prescaler
// - at reload: interrupt, count to one, continue
// - counting modes invert output at reload (code inverts only while out_en is set)
// - counting edge sets starting output level
// - start count used only on first pass
// - count minus start equals counted edges
// - comparator mode counts comparator output edges
// - pwm counts prescaled clocks, toggles at match
// - pwm reload: interrupt, count to one
// - polarity one: high, low at match
// - polarity zero: low, high at match
// - pwm start count governs first period
// - pwm period is reload times prescale
// - prescale divisors one to 128
// - count wraps from all ones to zero
`timescale 1ns/1ps
`include "tecp_cfg.svh"
module tecp_timer #(
    parameter int CNT_W = 16
)
(
    input wire logic sys_clk, // 250 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic tmr_in, // external timer input pin
    input wire logic cmp_in, // analog comparator output
    output logic tmr_out, // timer output level
    output logic tmr_out_oe, // timer output alternate function on
    output logic tmr_irq // one-cycle reload interrupt pulse
);
    ////////////////////////////////////////////////////////////////////////
    // elaboration check
    if (CNT_W < 2 || CNT_W > 32)
    begin : g_bad_width
        $error("CNT_W must lie between 2 and 32");
    end

    localparam logic [CNT_W-1:0] START = CNT_W'(`TECP_START_CNT);

    tecp_pkg::tecp_ctrl_t ctrl_q;
    tecp_pkg::tecp_mode_t mode;
    tecp_pkg::tecp_edges_t ext_edges;
    tecp_pkg::tecp_edges_t cmp_edges;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] rld_q;
    logic [CNT_W-1:0] pwm_q;
    logic [CNT_W-1:0] nxt_cnt;
    logic [`TECP_PRESC_W-1:0] presc_q;
    logic out_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic setup;
    logic wr;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_rld;
    logic wr_pwm;
    logic mapped;
    logic [31:0] rd_mux;
    logic ext_evt;
    logic cmp_evt;
    logic presc_hit;
    logic tick;
    logic at_rld;
    logic pwm_mode;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // last prescaler count for a divisor of two to the n
    function automatic logic [`TECP_PRESC_W-1:0] div_m1(input logic [2:0] n);
        logic [`TECP_PRESC_W:0] full;
        full = (`TECP_PRESC_W+1)'(1) << n;
        return `TECP_PRESC_W'(full - (`TECP_PRESC_W+1)'(1));
    endfunction

    // apb address compare on the word address
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr[7:2] == ofs[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detectors
    tecp_edge_det u_ext_edge
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(tmr_in),
        .edges(ext_edges)
    );

    tecp_edge_det u_cmp_edge
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(cmp_in),
        .edges(cmp_edges)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb decode; writes land at the access edge only
    assign setup = psel & ~penable;
    assign wr = psel & penable & pready_q & pwrite;
    assign wr_ctrl = wr & hit(paddr, `TECP_OFS_CTRL);
    assign wr_cnt = wr & hit(paddr, `TECP_OFS_COUNT);
    assign wr_rld = wr & hit(paddr, `TECP_OFS_RELOAD);
    assign wr_pwm = wr & hit(paddr, `TECP_OFS_PWM);
    assign mapped = hit(paddr, `TECP_OFS_CTRL) | hit(paddr, `TECP_OFS_COUNT)
        | hit(paddr, `TECP_OFS_RELOAD) | hit(paddr, `TECP_OFS_PWM)
        | hit(paddr, `TECP_OFS_STATUS);

    // read mux; unused upper bits read as zero
    always_comb
    begin
        rd_mux = 32'h0;
        if (hit(paddr, `TECP_OFS_CTRL))
            rd_mux = 32'(ctrl_q);
        else if (hit(paddr, `TECP_OFS_COUNT))
            rd_mux = 32'(cnt_q);
        else if (hit(paddr, `TECP_OFS_RELOAD))
            rd_mux = 32'(rld_q);
        else if (hit(paddr, `TECP_OFS_PWM))
            rd_mux = 32'(pwm_q);
        else if (hit(paddr, `TECP_OFS_STATUS))
            rd_mux[`TECP_STATUS_OUT_BIT] = out_q;
    end

    // zero-wait slave: data sampled in setup, ready in the access cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end
        else
        begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup)
                prdata_q <= pwrite ? 32'h0 : rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= tecp_pkg::tecp_ctrl_t'(`TECP_CTRL_RST);
            rld_q <= CNT_W'(`TECP_RELOAD_RST);
            pwm_q <= CNT_W'(`TECP_PWM_RST);
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= tecp_pkg::tecp_ctrl_t'(pwdata[`TECP_CTRL_W-1:0]);
            if (wr_rld)
                rld_q <= pwdata[CNT_W-1:0];
            if (wr_pwm)
                pwm_q <= pwdata[CNT_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // count source selection
    assign mode = tecp_pkg::tecp_mode_t'(ctrl_q.mode);
    assign pwm_mode = mode == tecp_pkg::TECP_MODE_PWM;
    assign ext_evt = ctrl_q.out_pol ? ext_edges.rise : ext_edges.fall;
    assign cmp_evt = ctrl_q.out_pol ? cmp_edges.rise : cmp_edges.fall;
    assign presc_hit = presc_q == div_m1(ctrl_q.presc);

    // edges advance the count directly, no prescaler in between
    always_comb
    begin
        unique case (mode)
            tecp_pkg::TECP_MODE_COUNTER: tick = ctrl_q.en & ext_evt;
            tecp_pkg::TECP_MODE_COMPARE: tick = ctrl_q.en & cmp_evt;
            tecp_pkg::TECP_MODE_PWM: tick = ctrl_q.en & presc_hit;
            default: tick = 1'b0; // code 3 holds the timer still
        endcase
    end

    assign at_rld = cnt_q == rld_q;
    assign nxt_cnt = cnt_q + CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////
    // prescaler; reset while stopped so each period starts aligned
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            presc_q <= '0;
        else if (!ctrl_q.en || !pwm_mode || presc_hit)
            presc_q <= '0;
        else
            presc_q <= presc_q + `TECP_PRESC_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // counter; a software write wins, it is the first-pass start value
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_q <= CNT_W'(`TECP_COUNT_RST);
        else if (wr_cnt)
            cnt_q <= pwdata[CNT_W-1:0];
        else if (tick)
            cnt_q <= at_rld ? START : nxt_cnt;
    end

    ////////////////////////////////////////////////////////////////////////
    // output level; polarity gives the level while stopped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            out_q <= 1'b0;
        else if (!ctrl_q.en)
            out_q <= ctrl_q.out_pol;
        else if (tick && at_rld)
        begin
            if (pwm_mode)
                out_q <= ctrl_q.out_pol;
            else if (ctrl_q.out_en)
                out_q <= ~out_q;
        end
        // flip on the tick that leaves the match count, so the first level lasts pwm ticks
        else if (tick && pwm_mode && cnt_q == pwm_q)
            out_q <= ~ctrl_q.out_pol;
    end

    // reload interrupt pulse
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irq_q <= 1'b0;
        else
            irq_q <= tick & at_rld;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tmr_out = out_q;
    assign tmr_out_oe = ctrl_q.out_en; // pin drive is a plain control flop
    assign tmr_irq = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence run_reload_s;
        ctrl_q.en && tick && at_rld && !wr_cnt && !wr_ctrl;
    endsequence

    sequence run_step_s;
        ctrl_q.en && tick && !at_rld && !wr_cnt && !wr_ctrl;
    endsequence

    edge_count_a: assert property (
        (mode == tecp_pkg::TECP_MODE_COUNTER && ext_evt) and run_step_s
        |=> cnt_q == $past(cnt_q) + CNT_W'(1))
        else $error("counter mode edge did not add one");

    wrong_edge_a: assert property (
        mode == tecp_pkg::TECP_MODE_COUNTER && ctrl_q.out_pol && ext_edges.fall
        && !ext_edges.rise && !wr_cnt |=> cnt_q == $past(cnt_q))
        else $error("unselected edge changed the count");

    no_presc_a: assert property (
        !pwm_mode && ctrl_q.en && !wr_cnt && !tick |=> cnt_q == $past(cnt_q))
        else $error("count moved without a qualifying edge");

    reload_one_a: assert property (
        run_reload_s |=> cnt_q == START && tmr_irq ##1 (!tmr_irq || rld_q == START))
        else $error("reload did not restart at one with one irq pulse");

    out_toggle_a: assert property (
        (!pwm_mode && ctrl_q.out_en) and run_reload_s |=> tmr_out != $past(tmr_out))
        else $error("counting mode reload did not invert the output");

    idle_level_a: assert property (
        !ctrl_q.en && !wr_ctrl |=> tmr_out == ctrl_q.out_pol)
        else $error("stopped output does not follow the polarity bit");

    cmp_count_a: assert property (
        (mode == tecp_pkg::TECP_MODE_COMPARE && cmp_evt) and run_step_s
        |=> cnt_q == $past(cnt_q) + CNT_W'(1))
        else $error("comparator edge did not add one");

    pwm_match_a: assert property (
        (pwm_mode && cnt_q == pwm_q) and run_step_s
        |=> tmr_out == !ctrl_q.out_pol && cnt_q == $past(cnt_q) + CNT_W'(1))
        else $error("pwm match did not set the active level");

    pwm_reload_a: assert property (
        (pwm_mode) and run_reload_s |=> tmr_out == ctrl_q.out_pol ##0 tmr_irq)
        else $error("pwm reload did not restore the start level");

    presc_tick_a: assert property (
        pwm_mode && ctrl_q.en && !wr_ctrl && presc_hit |=> !presc_hit || ctrl_q.presc == 3'h0)
        else $error("prescaler fired twice in a row above divisor one");

    wrap_zero_a: assert property (
        run_step_s and (cnt_q == '1) |=> cnt_q == '0)
        else $error("count did not wrap to zero");
endmodule

//--- hw/tecp_cfg.svh
// register offsets, reset values and timing constants of the event timer
`ifndef TECP_CFG_SVH
`define TECP_CFG_SVH
`define TECP_OFS_CTRL 8'h00
`define TECP_OFS_COUNT 8'h04
`define TECP_OFS_RELOAD 8'h08
`define TECP_OFS_PWM 8'h0c
`define TECP_OFS_STATUS 8'h10
`define TECP_CTRL_W 8
`define TECP_CTRL_RST 8'h00
`define TECP_COUNT_RST 16'h0001
`define TECP_RELOAD_RST 16'hffff
`define TECP_PWM_RST 16'h0000
`define TECP_START_CNT 16'h0001
`define TECP_PRESC_W 7
`define TECP_STATUS_OUT_BIT 0
`define TECP_SYNC_STAGES 2
`endif

//--- hw/tecp_pkg.sv
// types shared by the event timer files
package tecp_pkg;
    // operating modes held in the control register
    typedef enum logic [1:0]
    {
        TECP_MODE_COUNTER = 2'h0,
        TECP_MODE_COMPARE = 2'h1,
        TECP_MODE_PWM = 2'h2
    } tecp_mode_t;

    // control register layout, msb first
    typedef struct packed
    {
        logic [2:0] presc; // divisor is two to this power
        logic out_en; // timer output alternate function
        logic out_pol; // output_polarity_select
        logic [1:0] mode; // tecp_mode_t code
        logic en; // timer runs
    } tecp_ctrl_t;

    // edge pulses from one synchronised input
    typedef struct packed
    {
        logic rise;
        logic fall;
    } tecp_edges_t;
endpackage

//--- hw/tecp_edge_det.sv
// input synchroniser and edge detector for the timer inputs
`timescale 1ns/1ps
module tecp_edge_det
(
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic async_in, // raw input level
    output tecp_pkg::tecp_edges_t edges // one-cycle edge pulses
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser; only sync2_q may read sync1_q
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= async_in;
            sync2_q <= sync1_q;
        end
    end

    // previous sample for edge detection
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_q <= 1'b0;
        else
            prev_q <= sync2_q;
    end

    // edges from two settled samples, never from the first stage
    assign edges = {sync2_q & ~prev_q, ~sync2_q & prev_q};

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sync_delay_a: assert property (edges.rise |-> $past(async_in, 2) && !$past(async_in, 3))
        else $error("rise pulse without a delayed input rise");
endmodule

//--- dv/tecp_pin_model.sv
// far side model: a pin or comparator level that toggles on command
`timescale 1ns/1ps
module tecp_pin_model
(
    input wire logic sys_clk, // system clock
    output logic lvl // level seen by the timer input
);
    initial lvl = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // two clocks per level keeps the toggle rate at clock/4, the legal limit
    task automatic tog(input int n);
        repeat (n)
        begin
            repeat (2) @(posedge sys_clk);
            lvl <= ~lvl;
        end
    endtask
endmodule

//--- dv/tb.sv
// self-checking testbench of the event timer
`timescale 1ns/1ps
`include "tecp_cfg.svh"
module tb;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, tmr_out, tmr_out_oe, tmr_irq, tmr_in, cmp_in;
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int irqs = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    tecp_timer dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tmr_in(tmr_in), .cmp_in(cmp_in), .tmr_out(tmr_out),
        .tmr_out_oe(tmr_out_oe), .tmr_irq(tmr_irq));
    tecp_pin_model pin_u (.sys_clk(sys_clk), .lvl(tmr_in));
    tecp_pin_model cmp_u (.sys_clk(sys_clk), .lvl(cmp_in));

    // reload pulses and a hang guard
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (tmr_irq === 1'b1)
            irqs <= irqs + 1;
        if (cyc == 20000)
        begin
            mismatches++;
            finish_test;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer; waits for pready rather than assuming zero wait states
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, exp);
    endtask

    function automatic logic [31:0] ctl(input logic en, input logic [1:0] m,
        input logic pol, input logic oe, input logic [2:0] ps);
        tecp_pkg::tecp_ctrl_t c;
        c.presc = ps;
        c.out_en = oe;
        c.out_pol = pol;
        c.mode = m;
        c.en = en;
        return {24'h0, c};
    endfunction

    // stop, program, then start, in the order software must keep
    task automatic setup(input logic [1:0] m, input logic pol, input logic oe,
        input logic [2:0] ps, input logic [15:0] st, input logic [15:0] rl, input logic [15:0] pw);
        wr(`TECP_OFS_CTRL, ctl(1'b0, m, pol, oe, ps));
        wr(`TECP_OFS_COUNT, {16'h0, st});
        wr(`TECP_OFS_RELOAD, {16'h0, rl});
        wr(`TECP_OFS_PWM, {16'h0, pw});
        repeat (2) @(posedge sys_clk);
        chk("idle level", {31'h0, tmr_out}, {31'h0, pol});
        wr(`TECP_OFS_CTRL, ctl(1'b1, m, pol, oe, ps));
    endtask

    // toggle one source, then allow for the two-flop synchroniser
    task automatic tog(input logic sel_cmp, input int n);
        if (sel_cmp)
            cmp_u.tog(n);
        else
            pin_u.tog(n);
        repeat (8) @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rdc(`TECP_OFS_CTRL, 32'h0, "ctrl reset");
        rdc(`TECP_OFS_COUNT, 32'h1, "count reset");
        rdc(`TECP_OFS_RELOAD, 32'hffff, "reload reset");
        rdc(`TECP_OFS_PWM, 32'h0, "pwm reset");
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk("unmapped data", r, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("oe reset", {31'h0, tmr_out_oe}, 32'h0);
    endtask

    // prescale 128 set on purpose: edge modes must ignore it
    task automatic t_count(input logic [1:0] m, input logic pol);
        int i0;
        logic c;
        c = (m == tecp_pkg::TECP_MODE_COMPARE);
        setup(m, pol, 1'b1, 3'h7, 16'h0001, 16'h0004, 16'h0000);
        chk("oe on", {31'h0, tmr_out_oe}, 32'h1);
        tog(!c, 2);
        rdc(`TECP_OFS_COUNT, 32'h1, "other input ignored");
        tog(c, 1);
        rdc(`TECP_OFS_COUNT, {31'h0, pol} + 32'h1, "edge select");
        tog(c, 1);
        rdc(`TECP_OFS_COUNT, 32'h2, "one per edge");
        tog(c, 2);
        rdc(`TECP_OFS_COUNT, 32'h3, "count minus start");
        i0 = irqs;
        tog(c, 6);
        chk("reload irq", 32'(irqs - i0), 32'h1);
        rdc(`TECP_OFS_COUNT, 32'h2, "restart at one");
        chk("toggle at reload", {31'h0, tmr_out}, {31'h0, ~pol});
        rdc(`TECP_OFS_STATUS, {31'h0, ~pol}, "status level");
    endtask

    task automatic t_first_pass;
        int i0;
        setup(tecp_pkg::TECP_MODE_COMPARE, 1'b1, 1'b0, 3'h0, 16'hfffe, 16'h0003, 16'h0000);
        tog(1'b1, 4);
        rdc(`TECP_OFS_COUNT, 32'h0, "wrap");
        i0 = irqs;
        tog(1'b1, 10);
        chk("reload irq", 32'(irqs - i0), 32'h1);
        rdc(`TECP_OFS_COUNT, 32'h2, "first pass only");
        chk("no toggle when off", {31'h0, tmr_out}, 32'h1);
    endtask

    // the hang guard ends a wait that never sees a pulse
    task automatic wirq;
        do
            @(posedge sys_clk);
        while (tmr_irq !== 1'b1);
    endtask

    // period and high time measured between two reload pulses
    task automatic t_pwm(input logic pol, input logic [2:0] ps, input logic [15:0] pw,
        input logic [15:0] rl, input logic [15:0] st);
        int n;
        int h;
        setup(tecp_pkg::TECP_MODE_PWM, pol, 1'b1, ps, st, rl, pw);
        wirq;
        n = 0;
        h = 0;
        do
        begin
            h += (tmr_out === 1'b1);
            @(posedge sys_clk);
            n++;
        end
        while (tmr_irq !== 1'b1 && n < 3000);
        chk("pwm period", 32'(n), 32'(rl) << ps);
        chk("pwm high", 32'(h), (pol ? 32'(pw) : 32'(rl - pw)) << ps);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset;
        t_count(tecp_pkg::TECP_MODE_COUNTER, 1'b1);
        t_count(tecp_pkg::TECP_MODE_COUNTER, 1'b0);
        t_count(tecp_pkg::TECP_MODE_COMPARE, 1'b1);
        t_first_pass;
        t_pwm(1'b1, 3'h1, 16'h0003, 16'h0006, 16'h0001);
        t_pwm(1'b0, 3'h0, 16'h0002, 16'h0005, 16'h0001);
        t_pwm(1'b1, 3'h7, 16'h0001, 16'h0003, 16'h0002);
        finish_test;
    end
endmodule
